// ===== hdl/cmcc_checker.v
// configuration memory crc checker top
`timescale 1ns/100ps
`include "cmcc_defs.vh"
module cmcc_checker #(
	parameter FRAME_BITS = 64,
	parameter MEM_BITS   = 1024,
	parameter DIV_EXP    = 0
) (
	input  wire        ref_clk_in,
	input  wire        sys_rst_in,
	input  wire        clk_en_in,
	input  wire        config_restart_n_in,
	input  wire        crc_enable_in,
	input  wire        cfg_bit_valid_in,
	input  wire        cfg_bit_in,
	input  wire        cfg_done_in,
	input  wire [31:0] cfg_ref_crc_in,
	input  wire        mem_bit_in,
	input  wire        scan_update_in,
	input  wire [9:0]  scan_instr_in,
	input  wire        scan_shift_in,
	input  wire        scan_tdi_in,
	output reg         scan_tdo_out,
	output reg  [31:0] mem_addr_out,
	output reg         config_status_n_out,
	output reg         config_status_n_oe_out,
	output reg         error_flag_out,
	output reg         error_flag_oe_out,
	output reg  [31:0] crc_signature_out,
	output reg         user_mode_out
);
	localparam ST_CONFIG = 2'b00;
	localparam ST_START  = 2'b01;
	localparam ST_RUN    = 2'b10;
	localparam ST_END    = 2'b11;

	reg  [1:0]  state_r;
	reg  [31:0] crc_reference_store_r;
	reg  [31:0] crc_signature_r;
	reg  [31:0] acc_r;
	reg  [8:0]  div_cnt_r;
	reg  [9:0]  instr_r;
	wire [8:0]  div_max;
	wire        tick;
	wire        scan_active;
	wire        fb;
	wire [31:0] acc_nxt;
	wire        frame_err;
	wire        restart;

	assign restart     = !config_restart_n_in;
	assign div_max     = (9'h001 << DIV_EXP) - 9'h001;
	assign tick        = (div_cnt_r == div_max);
	assign scan_active = (instr_r == `CMCC_SCAN_INSTR) && (state_r != ST_CONFIG);
	assign fb          = acc_r[31] ^ mem_bit_in;
	// crc-32 over every memory bit
	assign acc_nxt = {acc_r[30:0], 1'b0} ^ (fb ? `CMCC_CRC32_POLY : 32'h00000000);

	cmcc_frame_check #(
		.FRAME_BITS (FRAME_BITS)
	) u_frame (
		.ref_clk_in    (ref_clk_in),
		.sys_rst_in    (sys_rst_in),
		.clk_en_in     (clk_en_in),
		.restart_in    (restart),
		.bit_valid_in  (cfg_bit_valid_in && (state_r == ST_CONFIG)),
		.bit_in        (cfg_bit_in),
		.frame_err_out (frame_err)
	);

	// scan instruction register, latched on update strobe
	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			instr_r <= 10'h000;
		else if (clk_en_in)
		begin
			if (restart)
				instr_r <= 10'h000;
			else if (scan_update_in)
				instr_r <= scan_instr_in;
		end
	end

	// reference store: loaded at end of config, scannable in user mode
	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			crc_reference_store_r <= `CMCC_REF_RST;
			scan_tdo_out          <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (state_r == ST_CONFIG && cfg_done_in && !restart)
				crc_reference_store_r <= cfg_ref_crc_in;
			else if (scan_active && scan_shift_in)
			begin
				// lsb leaves first; new bits enter at the top
				crc_reference_store_r <= {scan_tdi_in, crc_reference_store_r[31:1]};
				scan_tdo_out          <= crc_reference_store_r[0];
			end
		end
	end

	// checker sequence; scanning never stalls it
	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_r         <= ST_CONFIG;
			acc_r           <= `CMCC_CRC32_INIT;
			crc_signature_r <= `CMCC_SIG_RST;
			div_cnt_r       <= 9'h000;
			mem_addr_out    <= 32'h00000000;
		end
		else if (clk_en_in)
		begin
			if (restart)
			begin
				// checking stops only on restart
				state_r         <= ST_CONFIG;
				crc_signature_r <= `CMCC_SIG_RST;
				div_cnt_r       <= 9'h000;
				mem_addr_out    <= 32'h00000000;
			end
			else
			begin
				div_cnt_r <= tick ? 9'h000 : div_cnt_r + 9'h001;
				case (state_r)
				ST_CONFIG:
					if (cfg_done_in && !frame_err && crc_enable_in)
						state_r <= ST_START;
				ST_START:
					if (tick)
					begin
						acc_r        <= `CMCC_CRC32_INIT;
						mem_addr_out <= 32'h00000000;
						state_r      <= ST_RUN;
					end
				ST_RUN:
					if (tick)
					begin
						acc_r <= acc_nxt;
						if (mem_addr_out == MEM_BITS - 1)
							state_r <= ST_END;
						else
							mem_addr_out <= mem_addr_out + 32'h00000001;
					end
				ST_END:
					if (tick)
					begin
						// compare against reference only at pass end
						crc_signature_r <= acc_r ^ crc_reference_store_r;
						state_r         <= ST_START;
					end
				default:
					state_r <= ST_CONFIG;
				endcase
			end
		end
	end

	// registered pin outputs
	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			error_flag_out         <= 1'b0;
			error_flag_oe_out      <= 1'b0;
			config_status_n_out    <= 1'b0;
			config_status_n_oe_out <= 1'b0;
			crc_signature_out      <= `CMCC_SIG_RST;
			user_mode_out          <= 1'b0;
		end
		else if (clk_en_in)
		begin
			// flag held for the whole next pass since signature only moves at end
			error_flag_out      <= |crc_signature_r;
			// open drain, only while crc_enable_in is set: pull low while clean, release to the pull-up on error
			error_flag_oe_out   <= crc_enable_in && !(|crc_signature_r);
			config_status_n_out <= 1'b0;
			config_status_n_oe_out <= frame_err;
			crc_signature_out   <= crc_signature_r;
			user_mode_out       <= (state_r != ST_CONFIG);
		end
	end
endmodule // cmcc_checker

// ===== hdl/cmcc_defs.vh
// constants for the configuration memory crc checker
//
// Behaviour
// - error flag high whenever corruption found in configuration cells, low otherwise
// - error flag drives open-drain only when checking feature enabled
// - user mode computes one 32-bit crc spanning all configuration memory
// - each config frame's 16-bit crc shifted in after frame crc computed
// - frame crc mismatch drives config_status_n low
// - frame length is a device-specific parameter
// - two 32-bit registers: signature and reference store
// - error flag high whenever any signature bit non-zero
// - clean pass leaves signature all zero; non-zero means corruption
// - reference store loaded with precomputed crc at end of configuration
// - user mode uses stored reference in compute-and-compare circuit
// - scan instruction makes reference store a 32-bit shift chain
// - scan does not halt checking; checking continues with new reference
// - scan instruction has listed code, accepted only in user mode
// - flag stays high through next pass, drops if that pass clean
// - checker clock is base clock divided by power of two, 1..256
// - checking repeats until config_restart_n pulled low
`ifndef CMCC_DEFS_VH
`define CMCC_DEFS_VH
`define CMCC_CRC32_POLY     32'h04C11DB7
`define CMCC_CRC32_INIT     32'hFFFFFFFF
`define CMCC_CRC16_POLY     16'h8005
`define CMCC_CRC16_INIT     16'hFFFF
`define CMCC_SCAN_INSTR     10'h015
`define CMCC_INSTR_W        10
`define CMCC_SIG_RST        32'h00000000
`define CMCC_REF_RST        32'h00000000
`define CMCC_DIV_MAX_EXP    4'h8
`endif

// ===== hdl/cmcc_frame_check.v
// per-frame 16-bit crc checker used while configuring
`timescale 1ns/100ps
`include "cmcc_defs.vh"
module cmcc_frame_check #(
	parameter FRAME_BITS = 64
) (
	input  wire ref_clk_in,
	input  wire sys_rst_in,
	input  wire clk_en_in,
	input  wire restart_in,
	input  wire bit_valid_in,
	input  wire bit_in,
	output reg  frame_err_out
);
	localparam CW = 16;
	reg  [CW-1:0] crc_r;
	reg  [CW-1:0] rx_crc_r;
	reg  [15:0]   cnt_r;
	reg           in_crc_r;
	wire          fb;
	wire [CW-1:0] crc_nxt;

	assign fb      = crc_r[CW-1] ^ bit_in;
	assign crc_nxt = {crc_r[CW-2:0], 1'b0} ^ (fb ? `CMCC_CRC16_POLY : 16'h0000);

	// frame length set per device
	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			crc_r         <= `CMCC_CRC16_INIT;
			rx_crc_r      <= 16'h0000;
			cnt_r         <= 16'h0000;
			in_crc_r      <= 1'b0;
			frame_err_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (restart_in)
			begin
				crc_r         <= `CMCC_CRC16_INIT;
				cnt_r         <= 16'h0000;
				in_crc_r      <= 1'b0;
				frame_err_out <= 1'b0;
			end
			else if (bit_valid_in)
			begin
				if (!in_crc_r)
				begin
					crc_r <= crc_nxt;
					if (cnt_r == FRAME_BITS - 1)
					begin
						cnt_r    <= 16'h0000;
						in_crc_r <= 1'b1;
					end
					else
						cnt_r <= cnt_r + 16'h0001;
				end
				else
				begin
					// shift in the stored crc after the frame
					rx_crc_r <= {rx_crc_r[CW-2:0], bit_in};
					if (cnt_r == CW - 1)
					begin
						if ({rx_crc_r[CW-2:0], bit_in} != crc_r)
							frame_err_out <= 1'b1;
						cnt_r    <= 16'h0000;
						in_crc_r <= 1'b0;
						crc_r    <= `CMCC_CRC16_INIT;
					end
					else
						cnt_r <= cnt_r + 16'h0001;
				end
			end
		end
	end
endmodule // cmcc_frame_check

// ===== test/cmcc_sva_checker.sv
// assertions for the crc checker top
`timescale 1ns/100ps
module cmcc_sva #(parameter MEM_BITS = 16) (
	input wire        ref_clk_in,
	input wire        sys_rst_in,
	input wire        config_restart_n_in,
	input wire        crc_enable_in,
	input wire        cfg_done_in,
	input wire [31:0] mem_addr_out,
	input wire        config_status_n_oe_out,
	input wire        error_flag_out,
	input wire        error_flag_oe_out,
	input wire [31:0] crc_signature_out,
	input wire        user_mode_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_flag; error_flag_out == |crc_signature_out; endproperty
	property p_od; error_flag_oe_out |-> !error_flag_out; endproperty
	property p_oe; !crc_enable_in && !$past(crc_enable_in) |-> !error_flag_oe_out; endproperty
	// restart clears the signature, so it is left out here
	property p_hold;
		disable iff (sys_rst_in || !config_restart_n_in)
		$changed(crc_signature_out) |=> $stable(crc_signature_out)[*8];
	endproperty
	property p_rst; !config_restart_n_in |-> ##[1:2] (crc_signature_out == 0 && !user_mode_out); endproperty
	property p_stat; config_status_n_oe_out && config_restart_n_in |=> config_status_n_oe_out; endproperty
	// a frame error keeps the device in configuration, so it is left out here
	property p_start;
		cfg_done_in && config_restart_n_in && crc_enable_in && !config_status_n_oe_out
			|-> ##[1:3] user_mode_out;
	endproperty
	property p_addr; mem_addr_out < MEM_BITS; endproperty
	property p_cfg; !user_mode_out && !$past(user_mode_out) |-> crc_signature_out == 0; endproperty
	a_flag: assert property (p_flag) else $error("flag mismatch");
	a_oe: assert property (p_oe) else $error("flag driven");
	a_od: assert property (p_od) else $error("flag pin driven high");
	a_hold: assert property (p_hold) else $error("signature moved mid pass");
	a_rst: assert property (p_rst) else $error("restart ignored");
	a_stat: assert property (p_stat) else $error("status dropped");
	a_start: assert property (p_start) else $error("no user mode");
	a_addr: assert property (p_addr) else $error("address range");
	a_cfg: assert property (p_cfg) else $error("signature in config");
	c_rise: cover property ($rose(error_flag_out));
	c_fall: cover property ($fell(error_flag_out));
	c_user: cover property ($rose(user_mode_out));
endmodule // cmcc_sva
bind cmcc_checker cmcc_sva #(.MEM_BITS(MEM_BITS)) u_sva (
	.ref_clk_in             (ref_clk_in),
	.sys_rst_in             (sys_rst_in),
	.config_restart_n_in    (config_restart_n_in),
	.crc_enable_in          (crc_enable_in),
	.cfg_done_in            (cfg_done_in),
	.mem_addr_out           (mem_addr_out),
	.config_status_n_oe_out (config_status_n_oe_out),
	.error_flag_out         (error_flag_out),
	.error_flag_oe_out      (error_flag_oe_out),
	.crc_signature_out      (crc_signature_out),
	.user_mode_out          (user_mode_out)
);

// ===== test/cmcc_mem_model.sv
// config cell memory and flag pull-up
`timescale 1ns/100ps
module cmcc_mem_model #(parameter N = 16) (
	input  wire [31:0]  addr_in,
	input  wire [N-1:0] cells_in,
	input  wire         flag_in,
	input  wire         flag_oe_in,
	output wire         bit_out,
	output wire         pin_out
);
	assign bit_out = cells_in[addr_in % N];
	// released pin floats up through the resistor
	assign pin_out = flag_oe_in ? flag_in : 1'b1;
endmodule // cmcc_mem_model

// ===== test/tb.sv
// self-checking bench for the crc checker
`timescale 1ns/100ps
module tb;
	localparam N = 16;
	reg ref_clk_in = 0, rst = 1, rst_n = 0, en = 0, done = 0, vb = 0, cb = 0;
	reg upd = 0, sh = 0, tdi = 0, ce = 1;
	reg [9:0] instr = 0;
	reg [31:0] ref_v = 0, nref, hold_v;
	reg [N-1:0] cells = 0, keep;
	wire mb, fo, foe, pin, um, sn, snoe, tdo;
	wire [31:0] addr, sig;
	integer num_errors = 0, check_count = 0, seed = 281, cyc = 0, i;
	reg [31:0] expq[$];
	event ev;
	cmcc_checker #(.FRAME_BITS(64), .MEM_BITS(N)) uut (
		.ref_clk_in(ref_clk_in), .sys_rst_in(rst), .clk_en_in(ce),
		.config_restart_n_in(rst_n), .crc_enable_in(en), .cfg_bit_valid_in(vb),
		.cfg_bit_in(cb), .cfg_done_in(done), .cfg_ref_crc_in(ref_v), .mem_bit_in(mb),
		.scan_update_in(upd), .scan_instr_in(instr), .scan_shift_in(sh),
		.scan_tdi_in(tdi), .scan_tdo_out(tdo), .mem_addr_out(addr),
		.config_status_n_out(sn), .config_status_n_oe_out(snoe), .error_flag_out(fo),
		.error_flag_oe_out(foe), .crc_signature_out(sig), .user_mode_out(um));
	cmcc_mem_model #(.N(N)) u_mem (.addr_in(addr), .cells_in(cells), .flag_in(fo),
		.flag_oe_in(foe), .bit_out(mb), .pin_out(pin));
	function [31:0] crc(input [N-1:0] m);
		integer k;
		begin
			crc = 32'hFFFFFFFF;
			for (k = 0; k < N; k = k + 1)
				crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ m[k]) ? 32'h04C11DB7 : 32'h0);
		end
	endfunction
	function [15:0] crc16(input [63:0] d);
		integer k;
		begin
			crc16 = 16'hFFFF;
			for (k = 63; k >= 0; k = k - 1)
				crc16 = {crc16[14:0], 1'b0} ^ ((crc16[15] ^ d[k]) ? 16'h8005 : 16'h0);
		end
	endfunction
	// 64 data bits msb first, then the frame crc msb first; bad flips its lsb
	task frame(input [63:0] d, input bad);
		reg [15:0] c;
		begin
			c = crc16(d) ^ {15'h0, bad};
			for (i = 0; i < 80; i = i + 1)
			begin
				vb = 1;
				cb = (i < 64) ? d[63 - i] : c[79 - i];
				@(posedge ref_clk_in);
				#1;
			end
			vb = 0;
		end
	endtask
	task chk(input [31:0] a, input [31:0] e);
		begin
			check_count = check_count + 1;
			if (a !== e)
			begin
				num_errors = num_errors + 1;
				$display("[ERR] %0t got %h exp %h", $time, a, e);
			end
		end
	endtask
	// waits past two passes so the last finished one saw only the new state
	task pass(input [31:0] e, input [63:0] nm);
		begin
			repeat (2 * N + 8) @(posedge ref_clk_in);
			#1 expq.push_back(e);
			->ev;
			#1 $display("done %0s", nm);
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	always #4 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in)
	begin
		cyc = cyc + 1;
		if (cyc == 2000)
		begin
			num_errors = num_errors + 1;
			results;
		end
	end
	always @(ev)
	begin
		chk(sig, expq[0]);
		chk({31'h0, pin}, {31'h0, |expq.pop_front()});
	end
	initial
	begin
		repeat (2) @(posedge ref_clk_in);
		#1 rst = 0;
		rst_n = 1;
		en = 1;
		cells = $random(seed);
		frame({$random(seed), $random(seed)}, 1'b1);
		repeat (3) @(posedge ref_clk_in);
		#1 chk({31'h0, snoe}, 32'h1);
		chk({31'h0, sn}, 32'h0);
		done = 1;
		@(posedge ref_clk_in);
		#1 done = 0;
		repeat (3) @(posedge ref_clk_in);
		#1 chk({31'h0, um}, 32'h0);
		rst_n = 0;
		repeat (2) @(posedge ref_clk_in);
		#1 rst_n = 1;
		@(posedge ref_clk_in);
		#1 chk({31'h0, snoe}, 32'h0);
		$display("done bad frame");
		frame({$random(seed), $random(seed)}, 1'b0);
		repeat (3) @(posedge ref_clk_in);
		#1 chk({31'h0, snoe}, 32'h0);
		$display("done good frame");
		ref_v = crc(cells);
		done = 1;
		@(posedge ref_clk_in);
		#1 done = 0;
		pass(32'h0, "clean");
		ce = 0;
		hold_v = addr;
		repeat (5) @(posedge ref_clk_in);
		#1 chk(addr, hold_v);
		ce = 1;
		$display("done freeze");
		keep = cells;
		cells = cells ^ (1 << ($unsigned($random(seed)) % N));
		pass(crc(cells) ^ ref_v, "corrupt");
		cells = keep;
		#1 chk({31'h0, fo}, 32'h1);
		pass(32'h0, "recover");
		nref = $random(seed);
		instr = 10'h015;
		upd = 1;
		@(posedge ref_clk_in);
		#1 upd = 0;
		sh = 1;
		for (i = 0; i < 32; i = i + 1)
		begin
			tdi = nref[i];
			@(posedge ref_clk_in);
			#1 chk({31'h0, tdo}, {31'h0, ref_v[i]});
		end
		sh = 0;
		pass(crc(cells) ^ nref, "inject");
		rst_n = 0;
		en = 0;
		repeat (4) @(posedge ref_clk_in);
		#1 chk(sig, 32'h0);
		chk({31'h0, foe}, 32'h0);
		$display("done restart");
		results;
	end
endmodule // tb
